// ==== hw/udma_engine.sv ====
// four-channel interrupt-started micro dma engine with axi4-lite registers
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
`include "udma_defines.svh"
module udma_engine #(
    parameter int CH_NUM = 4                        // channel count
) (
    input  wire logic              aclk,            // system clock
    input  wire logic              aresetn,         // sync reset, low
    input  wire udma_pkg::axi_req_t axi_in,         // axi4-lite master side
    output      udma_pkg::axi_rsp_t axi_out,        // axi4-lite slave answers
    input  wire logic [18:0]       irq_pending,     // source request flags
    input  wire logic [2:0]        cpu_interrupt_mask, // cpu mask level
    input  wire logic              cpu_halted,      // cpu in halt standby
    input  wire logic              queue_ge3,       // fetch queue holds 3+
    input  wire logic              src_bus8,        // source area 8-bit
    input  wire logic              dst_bus8,        // dest area 8-bit
    input  wire logic [31:0]       mem_rdata,       // read data
    output      udma_pkg::mem_t    mem,             // memory bus drive
    output      logic [18:0]       src_clear,       // clear source flag
    output      logic [18:0]       dma_claim,       // sources bound to dma
    output      logic [3:0]        dma_end_irq,     // end pulse per channel
    output      logic [15:0]       dma_end_vec,     // vector of last end
    output      logic              cpu_stall        // cycle steal to cpu
);

    localparam logic [8*`SRC_NUM-1:0] VEC_TBL = `VEC_TABLE;

    // the struct and the map are laid out for exactly four channels
    // four channels fixed
    if (CH_NUM != 4) begin : g_chk
        $error("udma_engine supports exactly four channels");
    end

    udma_pkg::state_t q;
    udma_pkg::state_t n;
    logic [3:0]       pend;
    logic             accept;

    // start vector code to {valid, source index}
    function automatic logic [5:0] vec_src(input logic [7:0] v);
        logic [5:0] r;
        r = 6'h00;
        for (int i = 0; i < `SRC_NUM; i++) begin
            if (v == VEC_TBL[i*8 +: 8]) begin
                r = {1'b1, 5'(i)};
            end
        end
        return r;
    endfunction

    // lowest set channel number
    function automatic logic [1:0] first_ch(input logic [3:0] p);
        logic [1:0] r;
        r = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (p[i]) begin
                r = 2'(i);
            end
        end
        return r;
    endfunction

    // states of one read or write phase
    function automatic logic [2:0] phase_len(input logic narrow, input logic odd,
                                             input logic [1:0] sz);
        logic [2:0] r;
        r = `RW_STATES;
        if (narrow || odd) begin
            r = r + `EXTRA_STATES;
        end
        if (sz == `SIZE_LONG) begin
            r = r + `EXTRA_STATES;
        end
        return r;
    endfunction

    // byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // address stride in bytes; the reserved size code steps like a long
    function automatic logic [31:0] stride(input logic [1:0] zz);
        return (zz == 2'h0) ? 32'h1 : (zz == 2'h1) ? 32'h2 : 32'h4;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a == `REG_SW_DMA_REQUEST) || (a == `REG_BURST_SELECT) ||
               (a == `REG_STATUS) || (a[7:6] == `CH_REGION);
    endfunction

    // register read mux
    function automatic logic [31:0] rd_reg(input udma_pkg::state_t s,
                                           input logic [7:0] a);
        logic [31:0] r;
        logic [1:0]  c;
        r = `RESET_VALUE;
        c = a[5:4];
        if (a == `REG_SW_DMA_REQUEST) begin
            r[3:0] = s.swreq;
        end else if (a == `REG_BURST_SELECT) begin
            r[3:0] = s.burst;
        end else if (a == `REG_STATUS) begin
            r[3:0] = {s.ch, s.hw, s.st != udma_pkg::ST_IDLE};
        end else if (a[7:6] == `CH_REGION) begin
            case (a[3:2])
                `CH_START_VECTOR: r[7:0] = s.vec[c];
                `CH_SRC_ADDR:     r = s.sa[c];
                `CH_DST_ADDR:     r = s.da[c];
                default:          r = {11'h000, s.mode[c], s.cnt[c]};
            endcase
        end
        return r;
    endfunction

    // pending requests per channel
    always_comb begin
        logic [5:0] s;
        s = 6'h00;
        for (int c = 0; c < 4; c++) begin
            s = vec_src(q.vec[c]);
            pend[c] = q.swreq[c] | (s[5] & irq_pending[s[4:0]]);
        end
        accept = (q.st == udma_pkg::ST_IDLE) && (|pend) && !cpu_halted &&
                 (cpu_interrupt_mask != `MASK_ALL_OFF);
    end

    // next state of bus slave, registers and transfer sequencer
    always_comb begin
        logic [5:0]  s;
        logic [1:0]  c;
        logic [3:0]  sw_set;
        logic [31:0] m;
        logic [31:0] step;
        logic [2:0]  md;
        s      = 6'h00;
        c      = 2'h0;
        sw_set = 4'h0;
        m      = `RESET_VALUE;
        step   = `RESET_VALUE;
        md     = q.mode[q.ch][4:2];
        n      = q;
        n.clr  = '0;
        n.endp = '0;

        // axi4-lite: answers drop once taken
        if (q.axi.bvalid && axi_in.bready) begin
            n.axi.bvalid = 1'b0;
        end
        if (q.axi.rvalid && axi_in.rready) begin
            n.axi.rvalid = 1'b0;
        end
        if (axi_in.awvalid && q.axi.awready) begin
            n.awh = 1'b1;
            n.awa = axi_in.awaddr;
        end
        if (axi_in.wvalid && q.axi.wready) begin
            n.wh = 1'b1;
            n.wd = axi_in.wdata;
            n.ws = axi_in.wstrb;
        end
        // write once both halves are held
        if (n.awh && n.wh && !n.axi.bvalid) begin
            n.awh        = 1'b0;
            n.wh         = 1'b0;
            n.axi.bvalid = 1'b1;
            n.axi.bresp  = mapped(n.awa) ? `RESP_OKAY : `RESP_SLVERR;
            c            = n.awa[5:4];
            if (n.awa == `REG_SW_DMA_REQUEST) begin
                m      = merge(`RESET_VALUE, n.wd, n.ws);
                sw_set = m[3:0];
            end else if (n.awa == `REG_BURST_SELECT) begin
                m       = merge({28'h0, q.burst}, n.wd, n.ws);
                n.burst = m[3:0];
            end else if (n.awa[7:6] == `CH_REGION) begin
                case (n.awa[3:2])
                    `CH_START_VECTOR: begin
                        m        = merge({24'h0, q.vec[c]}, n.wd, n.ws);
                        n.vec[c] = m[7:0];
                    end
                    `CH_SRC_ADDR: n.sa[c] = merge(q.sa[c], n.wd, n.ws);
                    `CH_DST_ADDR: n.da[c] = merge(q.da[c], n.wd, n.ws);
                    default: begin
                        m         = merge({11'h000, q.mode[c], q.cnt[c]}, n.wd, n.ws);
                        n.cnt[c]  = m[15:0];
                        n.mode[c] = m[`MODE_LSB +: 5];
                    end
                endcase
            end
        end
        if (axi_in.arvalid && q.axi.arready) begin
            n.axi.rvalid = 1'b1;
            n.axi.rdata  = rd_reg(q, axi_in.araddr);
            n.axi.rresp  = mapped(axi_in.araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end

        // transfer sequencer; its register updates win over software, except the swreq start bits
        case (q.st)
            udma_pkg::ST_IDLE: begin
                if (accept) begin
                    n.ch  = first_ch(pend);
                    n.hw  = !q.swreq[n.ch];
                    n.st  = udma_pkg::ST_FETCH;
                    n.tmr = `FETCH_STATES - 3'd1;
                    s     = vec_src(q.vec[n.ch]);
                    if (n.hw) begin
                        n.clr[s[4:0]] = 1'b1;
                    end
                end
            end
            udma_pkg::ST_FETCH: begin
                n.tmr = q.tmr - 3'd1;
                if (q.tmr == 3'd0) begin
                    if (md == `MODE_COUNTER) begin
                        n.st  = udma_pkg::ST_DUMMY;
                        n.tmr = `CNTMODE_STATES - `FETCH_STATES - 3'd1;
                    end else begin
                        n.st  = udma_pkg::ST_READ;
                        n.tmr = phase_len(src_bus8, q.sa[q.ch][0], q.mode[q.ch][1:0]) - 3'd1;
                        n.mem.addr = q.sa[q.ch][23:0];
                        n.mem.size = q.mode[q.ch][1:0];
                    end
                end
            end
            udma_pkg::ST_READ: begin
                n.tmr = q.tmr - 3'd1;
                if (q.tmr == 3'd0) begin
                    n.data = mem_rdata;
                    n.st   = udma_pkg::ST_DUMMY;
                    // one dummy state, not the wrapped count
                    n.tmr  = 3'd0;
                end
            end
            udma_pkg::ST_DUMMY: begin
                // address stays as in the last read state; in counter mode it keeps the address of an earlier transfer
                n.tmr = q.tmr - 3'd1;
                if (q.tmr == 3'd0) begin
                    if (md == `MODE_COUNTER) begin
                        n.st = udma_pkg::ST_DONE;
                    end else begin
                        n.st = udma_pkg::ST_WRITE;
                        n.tmr = phase_len(dst_bus8, q.da[q.ch][0], q.mode[q.ch][1:0]) - 3'd1;
                        n.mem.addr  = q.da[q.ch][23:0];
                        n.mem.wdata = q.data;
                    end
                end
            end
            udma_pkg::ST_WRITE: begin
                n.tmr = q.tmr - 3'd1;
                if (q.tmr == 3'd0) begin
                    n.st = udma_pkg::ST_DONE;
                end
            end
            udma_pkg::ST_DONE: begin
                step = stride(q.mode[q.ch][1:0]);
                case (md)
                    `MODE_DST_INC: n.da[q.ch] = q.da[q.ch] + step;
                    `MODE_DST_DEC: n.da[q.ch] = q.da[q.ch] - step;
                    `MODE_SRC_INC: n.sa[q.ch] = q.sa[q.ch] + step;
                    `MODE_SRC_DEC: n.sa[q.ch] = q.sa[q.ch] - step;
                    `MODE_COUNTER: n.sa[q.ch] = q.sa[q.ch] + 32'h1;
                    default: ;
                endcase
                n.cnt[q.ch] = q.cnt[q.ch] - 16'h1;
                if (n.cnt[q.ch] == 16'h0) begin
                    n.endp[q.ch]  = 1'b1;
                    n.endv        = `END_VEC_BASE + (`END_VEC_STEP * {14'h0, q.ch});
                    n.vec[q.ch]   = 8'h00;
                    n.swreq[q.ch] = 1'b0;
                    n.st          = udma_pkg::ST_IDLE;
                end else if (q.burst[q.ch]) begin
                    n.st  = udma_pkg::ST_FETCH;
                    n.tmr = `FETCH_STATES - 3'd1;
                end else begin
                    n.swreq[q.ch] = 1'b0;
                    n.st          = udma_pkg::ST_IDLE;
                end
            end
            default: n.st = udma_pkg::ST_IDLE;
        endcase

        // a software start written with the clear still lands
        n.swreq = n.swreq | sw_set;

        // end interrupts are not in the table
        n.claim = '0;
        for (int k = 0; k < 4; k++) begin
            s = vec_src(n.vec[k]);
            if (s[5]) begin
                n.claim[s[4:0]] = 1'b1;
            end
        end

        // strobes and readies follow the next state
        n.stall       = n.st != udma_pkg::ST_IDLE;
        n.mem.fetch   = (n.st == udma_pkg::ST_FETCH) && !queue_ge3;
        n.mem.rd      = n.st == udma_pkg::ST_READ;
        n.mem.wr      = n.st == udma_pkg::ST_WRITE;
        n.axi.awready = !n.awh && !n.axi.bvalid;
        n.axi.wready  = !n.wh && !n.axi.bvalid;
        n.axi.arready = !n.axi.rvalid;
    end

    // whole state in one register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // outputs straight from the state register
    assign axi_out     = q.axi;
    assign mem         = q.mem;
    assign src_clear   = q.clr;
    assign dma_claim   = q.claim;
    assign dma_end_irq = q.endp;
    assign dma_end_vec = q.endv;
    assign cpu_stall   = q.stall;

    // helpers for the checks below
    logic [15:0] cnt_cur;
    logic [3:0]  pend_p;
    assign cnt_cur = q.cnt[q.ch];
    assign pend_p  = pend;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence seq_enter_fetch;
        q.st == udma_pkg::ST_IDLE ##1 q.st == udma_pkg::ST_FETCH;
    endsequence

    sequence seq_done_last;
        q.st == udma_pkg::ST_DONE && cnt_cur == 16'h1;
    endsequence

    sequence seq_read_to_dummy;
        q.st == udma_pkg::ST_READ ##1 q.st == udma_pkg::ST_DUMMY;
    endsequence

    AST_MASK_SEVEN: assert property (
        q.st == udma_pkg::ST_IDLE && cpu_interrupt_mask == `MASK_ALL_OFF
        |=> q.st == udma_pkg::ST_IDLE) else $error("dma accepted under mask seven");

    AST_HALT_HOLD: assert property (
        q.st == udma_pkg::ST_IDLE && cpu_halted |=> !q.stall)
        else $error("dma accepted during halt");

    AST_SRC_CLEAR: assert property (
        seq_enter_fetch |-> (q.hw ? $onehot(src_clear) : src_clear == 19'h0))
        else $error("source flag clear wrong on acceptance");

    AST_FETCH_LEN: assert property (
        seq_enter_fetch |-> q.st == udma_pkg::ST_FETCH [*3] ##1
        q.st != udma_pkg::ST_FETCH) else $error("fetch phase not three states");

    AST_DUMMY_ONE: assert property (
        seq_read_to_dummy |=> q.st == udma_pkg::ST_WRITE) else $error("dummy state not single");

    AST_END_UNBIND: assert property (
        seq_done_last |=> dma_end_irq == (4'h1 << q.ch) && q.vec[q.ch] == 8'h00
        && q.st == udma_pkg::ST_IDLE) else $error("end of count not handled");

    AST_END_VECTOR: assert property (
        |dma_end_irq |-> dma_end_vec == `END_VEC_BASE + {12'h0, q.ch, 2'h0})
        else $error("end vector mismatch");

    AST_COUNT_DEC: assert property (
        q.st == udma_pkg::ST_DONE |=> cnt_cur == $past(cnt_cur) - 16'h1)
        else $error("counter not decremented by one");

    AST_NO_END_MID: assert property (
        q.st == udma_pkg::ST_DONE && cnt_cur != 16'h1 |=> dma_end_irq == 4'h0)
        else $error("end pulse before count reached zero");

    AST_ARB_LOW: assert property (
        accept && pend_p[0] |=> q.ch == 2'h0 && q.st == udma_pkg::ST_FETCH)
        else $error("channel 0 lost arbitration");

endmodule

// ==== hw/udma_defines.svh ====
// offsets, field positions, reset values and timing counts of the micro dma engine
`ifndef UDMA_DEFINES_SVH
`define UDMA_DEFINES_SVH

// global register byte offsets
`define REG_SW_DMA_REQUEST 8'h00
`define REG_BURST_SELECT   8'h04
`define REG_STATUS         8'h08
// channel region 0x40..0x7f, channel n at 0x40 + 0x10*n
`define CH_REGION          2'h1
// word index inside one channel block
`define CH_START_VECTOR    2'h0
`define CH_SRC_ADDR        2'h1
`define CH_DST_ADDR        2'h2
`define CH_COUNT_MODE      2'h3
// mode field sits above the counter in the count/mode word
`define MODE_LSB           16
`define RESET_VALUE        32'h0000_0000

// interrupt side constants
`define MASK_ALL_OFF       3'h7
`define END_VEC_BASE       16'h00a0
`define END_VEC_STEP       16'h0004
`define SRC_NUM            19
// start vector codes, index 0 in the low byte
`define VEC_TABLE {8'h27, 8'h26, 8'h25, 8'h24, 8'h23, 8'h22, 8'h21, 8'h1f, 8'h1c, \
    8'h1b, 8'h18, 8'h17, 8'h16, 8'h15, 8'h14, 8'h13, 8'h10, 8'h0f, 8'h0a}

// transfer mode codes in mode[4:2], long size code in mode[1:0]
`define MODE_DST_INC       3'h0
`define MODE_DST_DEC       3'h1
`define MODE_SRC_INC       3'h2
`define MODE_SRC_DEC       3'h3
`define MODE_FIXED         3'h4
`define MODE_COUNTER       3'h5
`define SIZE_LONG          2'h2

// cycle counts of one transfer, one state per clock
`define FETCH_STATES       3'd3
`define RW_STATES          3'd2
`define EXTRA_STATES       3'd2
`define CNTMODE_STATES     3'd5

`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ==== hw/udma_pkg.sv ====
// types of the micro dma engine
package udma_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH,
        ST_READ,
        ST_DUMMY,
        ST_WRITE,
        ST_DONE
    } fsm_t;

    typedef struct packed {
        logic [7:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [7:0]  araddr;
        logic        arvalid;
        logic        rready;
    } axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axi_rsp_t;

    typedef struct packed {
        logic        fetch;
        logic        rd;
        logic        wr;
        logic [23:0] addr;
        logic [1:0]  size;
        logic [31:0] wdata;
    } mem_t;

    typedef struct packed {
        fsm_t              st;
        logic [1:0]        ch;
        logic [2:0]        tmr;
        logic              hw;
        logic [31:0]       data;
        logic [3:0][7:0]   vec;
        logic [3:0][31:0]  sa;
        logic [3:0][31:0]  da;
        logic [3:0][15:0]  cnt;
        logic [3:0][4:0]   mode;
        logic [3:0]        swreq;
        logic [3:0]        burst;
        logic [18:0]       clr;
        logic [18:0]       claim;
        logic [3:0]        endp;
        logic [15:0]       endv;
        logic              stall;
        mem_t              mem;
        axi_rsp_t          axi;
        logic              awh;
        logic              wh;
        logic [7:0]        awa;
        logic [31:0]       wd;
        logic [3:0]        ws;
    } state_t;

endpackage

// ==== verif/udma_mem_model.sv ====
// memory and i/o bus model at the far side of the dma engine
`timescale 1ns/10ps
module udma_mem_model (
    input  wire logic           aclk,             // system clock
    input  wire udma_pkg::mem_t mem,              // engine bus drive
    output      logic [31:0]    mem_rdata = '0,   // read data to engine
    output      logic [23:0]    waddr = '0,       // last write address
    output      logic [31:0]    wdata = '0        // last write data
);
    // read data follows the address; off-read it inverts so stale data never matches
    always @(posedge aclk) begin
        if (mem.rd) begin
            mem_rdata <= {8'h5a, mem.addr};
        end else begin
            mem_rdata <= ~mem_rdata;
        end
        if (mem.wr) begin
            waddr <= mem.addr;
            wdata <= mem.wdata;
        end
    end
endmodule

// ==== verif/interrupt_driven_micro_dma_bench.sv ====
// self-checking bench of the micro dma engine
`timescale 1ns/10ps
module interrupt_driven_micro_dma_bench;
    logic               aclk;
    logic               aresetn;
    udma_pkg::axi_req_t axi_in;
    udma_pkg::axi_rsp_t axi_out;
    logic [18:0]        irq;
    logic [2:0]         mask;
    logic               halt;
    logic [31:0]        mrd;
    udma_pkg::mem_t     mem;
    logic [18:0]        clr;
    logic [18:0]        claim;
    logic [3:0]         eirq;
    logic [15:0]        evec;
    logic               stall;
    logic [23:0]        waddr;
    logic [31:0]        wdata;
    logic [31:0]        rd;
    logic [1:0]         rsp;
    logic               q3;
    logic               s8;
    logic               d8;
    int                 n_mismatch;
    int                 checks;
    int                 n;
    int                 n_end;
    int                 n_stall;
    int                 n_fetch;

    initial aclk = 1'b0;
    always #5 aclk = ~aclk;

    udma_engine #(.CH_NUM(4)) i_udma_engine (.aclk(aclk), .aresetn(aresetn),
        .axi_in(axi_in), .axi_out(axi_out), .irq_pending(irq), .cpu_interrupt_mask(mask),
        .cpu_halted(halt), .queue_ge3(q3), .src_bus8(s8), .dst_bus8(d8),
        .mem_rdata(mrd), .mem(mem), .src_clear(clr), .dma_claim(claim),
        .dma_end_irq(eirq), .dma_end_vec(evec), .cpu_stall(stall));
    udma_mem_model i_udma_mem_model (.aclk(aclk), .mem(mem), .mem_rdata(mrd),
        .waddr(waddr), .wdata(wdata));

    // end pulses of channel 0, to prove none came early
    always @(posedge aclk) begin
        if (eirq[0] === 1'b1) n_end++;
    end

    // busy and fetch cycles of one transfer; zeroed only while idle
    always @(posedge aclk) begin
        if (stall === 1'b1) n_stall++;
        if (mem.fetch === 1'b1) n_fetch++;
    end

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // both halves offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        axi_in.awaddr <= a;
        axi_in.wdata <= d;
        axi_in.awvalid <= 1'b1;
        axi_in.wvalid <= 1'b1;
        axi_in.bready <= 1'b1;
        // no cycle limit; the wait ends on bvalid, or else by the watchdog
        do begin
            @(posedge aclk);
            if (axi_out.awready === 1'b1) axi_in.awvalid <= 1'b0;
            if (axi_out.wready === 1'b1) axi_in.wvalid <= 1'b0;
        end while (axi_out.bvalid !== 1'b1);
        rsp = axi_out.bresp;
        axi_in.bready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        axi_in.araddr <= a;
        axi_in.arvalid <= 1'b1;
        axi_in.rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (axi_out.arready === 1'b1) axi_in.arvalid <= 1'b0;
        end while (axi_out.rvalid !== 1'b1);
        rd = axi_out.rdata;
        rsp = axi_out.rresp;
        axi_in.rready <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        rdr(a);
        cmp(nm, e, rd);
    endtask

    task automatic wait_end(input int c);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (eirq[c] !== 1'b1 && n < 200);
        cmp("end pulse", 32'h1, {31'h0, eirq[c]});
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // a whole run is a few hundred cycles; the watchdog fires after 10000
    initial begin
        #100000;
        n_mismatch++;
        give_verdict();
    end

    initial begin
        axi_in = '0;
        axi_in.wstrb = 4'hf;
        irq = '0;
        mask = 3'h0;
        halt = 1'b0;
        q3 = 1'b0;
        s8 = 1'b0;
        d8 = 1'b0;
        aresetn = 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        chk("ch0 count", 8'h4c, 32'h0);
        rdr(8'h20);
        cmp("unmapped resp", 32'h2, {30'h0, rsp});
        cmp("unmapped data", 32'h0, rd);
        wr(8'h20, 32'h1);
        cmp("unmapped wr resp", 32'h2, {30'h0, rsp});
        chk("status idle", 8'h08, 32'h0);
        $display("test reset done");
        // software word transfer, upper address byte must not reach the bus
        wr(8'h54, 32'h1200_3000);
        wr(8'h58, 32'h0000_0100);
        wr(8'h5c, 32'h0001_0001);
        n_stall = 0;
        n_fetch = 0;
        wr(8'h00, 32'h2);
        wait_end(1);
        cmp("end vector", 32'ha4, {16'h0, evec});
        cmp("write addr", 32'h100, {8'h0, waddr});
        cmp("write data", 32'h3000, {16'h0, wdata[15:0]});
        cmp("stall cycles", 32'h9, n_stall);
        cmp("fetch cycles", 32'h3, n_fetch);
        cmp("bus size", 32'h1, {30'h0, mem.size});
        chk("ch1 dest", 8'h58, 32'h102);
        chk("ch1 count", 8'h5c, 32'h0001_0000);
        chk("sw request", 8'h00, 32'h0);
        $display("test software start done");
        // source used only for dma; level zero lives in the controller
        wr(8'h40, 32'h1f);
        wr(8'h44, 32'h40);
        wr(8'h4c, 32'h0008_0002);
        mask <= 3'h7;
        irq[11] <= 1'b1;
        repeat (20) @(posedge aclk);
        cmp("stall masked", 32'h0, {31'h0, stall});
        cmp("claim", 32'h1, {31'h0, claim[11]});
        mask <= 3'h0;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (clr[11] !== 1'b1 && n < 50);
        cmp("source clear", 32'h1, {31'h0, clr[11]});
        irq[11] <= 1'b0;
        repeat (20) @(posedge aclk);
        cmp("no end irq", 32'h0, n_end);
        chk("ch0 count", 8'h4c, 32'h0008_0001);
        chk("ch0 source", 8'h44, 32'h41);
        halt <= 1'b1;
        irq[11] <= 1'b1;
        repeat (20) @(posedge aclk);
        cmp("stall halted", 32'h0, {31'h0, stall});
        halt <= 1'b0;
        wait_end(0);
        cmp("end vector", 32'ha0, {16'h0, evec});
        irq[11] <= 1'b0;
        chk("ch0 vector", 8'h40, 32'h0);
        cmp("claim dropped", 32'h0, {31'h0, claim[11]});
        $display("test hardware start done");
        // channel 2 by source, channel 3 by software in burst, released together
        wr(8'h60, 32'h21);
        wr(8'h6c, 32'h1);
        wr(8'h7c, 32'h2);
        wr(8'h04, 32'h8);
        halt <= 1'b1;
        irq[12] <= 1'b1;
        wr(8'h00, 32'h8);
        halt <= 1'b0;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (eirq === 4'h0 && n < 200);
        cmp("first end", 32'h4, {28'h0, eirq});
        irq[12] <= 1'b0;
        wait_end(3);
        $display("test arbitration done");
        // long unit over narrow buses with a full queue, then a counter-mode unit
        q3 <= 1'b1;
        s8 <= 1'b1;
        d8 <= 1'b1;
        wr(8'h5c, 32'h0002_0001);
        n_stall = 0;
        n_fetch = 0;
        wr(8'h00, 32'h2);
        wait_end(1);
        cmp("long stall", 32'h11, n_stall);
        cmp("queue fetch", 32'h0, n_fetch);
        cmp("long size", 32'h2, {30'h0, mem.size});
        chk("ch1 dest long", 8'h58, 32'h106);
        q3 <= 1'b0;
        s8 <= 1'b0;
        d8 <= 1'b0;
        wr(8'h5c, 32'h0014_0001);
        n_stall = 0;
        n_fetch = 0;
        wr(8'h00, 32'h2);
        wait_end(1);
        cmp("counter stall", 32'h6, n_stall);
        cmp("counter fetch", 32'h3, n_fetch);
        chk("ch1 source", 8'h54, 32'h1200_3001);
        $display("test modes done");
        give_verdict();
    end
endmodule
